// ---- hw/fir_eq_pkg.sv ----
// Shared constants and carriers for the programmable equalizer filter block.
// Assumes a 32-bit classic Wishbone register bus and 12-bit two-channel samples.
package fir_eq_pkg;

  localparam int SampleW = 12;
  localparam int CoefW = 12;
  localparam int RegW = 16;
  localparam int AccW = 32;

  // Register indices; byte address is four times the index
  localparam logic [10:0] CfgIdx = 11'h400;
  localparam logic [10:0] StatusIdx = 11'h401;
  localparam logic [10:0] CoefATap0Idx = 11'h418;
  localparam logic [10:0] CoefBTap0Idx = 11'h438;
  localparam logic [10:0] CoefStep = 11'h002;

  // Configuration field positions and values
  localparam int ModeLsb = 0;
  localparam int ScwLsb = 2;
  localparam int MergeBit = 5;
  localparam int ShareBit = 6;
  localparam logic [1:0] ModeEnable = 2'h2;
  localparam logic [7:0] CfgReset = 8'h00;
  localparam logic [15:0] CoefReset = 16'h0000;
  localparam logic [2:0] ScwMax = 3'h6;
  localparam int ScwBase = 16;
  localparam int CenterShift = 10;

  // Status field positions
  localparam int StActiveBit = 0;
  localparam int StReservedModeBit = 1;
  localparam int StScwIllegalBit = 2;
  localparam int StOutValidBit = 3;
  localparam int StCountLsb = 16;

  typedef struct packed {
    logic [SampleW-1:0] chanB;
    logic [SampleW-1:0] chanA;
  } sample_pair_s;

endpackage

// ---- hw/fir_tap_sum.sv ----
// Weighted tap sum for one filter channel, saturated to the sample width.
// Assumes samples and coefficients arrive newest first; purely combinational.
`timescale 1ns/1ps
module fir_tap_sum #(
  parameter int NumTaps = 5
) (
  input wire logic [NumTaps-1:0][fir_eq_pkg::SampleW-1:0] samples, // Window, newest at 0
  input wire logic [NumTaps-1:0][fir_eq_pkg::CoefW-1:0] coefs, // Tap coefficients
  input wire logic [2:0] sideWeight, // Side coefficient weight field
  output logic [fir_eq_pkg::SampleW-1:0] result // Filtered sample
);
  localparam int Center = NumTaps / 2;
  localparam int ProdW = fir_eq_pkg::SampleW + fir_eq_pkg::CoefW;

  function automatic logic [fir_eq_pkg::SampleW-1:0] saturate(input logic signed [fir_eq_pkg::AccW-1:0] v);
    logic signed [fir_eq_pkg::AccW-1:0] hi;
    logic signed [fir_eq_pkg::AccW-1:0] lo;
    hi = (fir_eq_pkg::AccW'(1) <<< (fir_eq_pkg::SampleW - 1)) - 1;
    lo = -(fir_eq_pkg::AccW'(1) <<< (fir_eq_pkg::SampleW - 1));
    if (v > hi) begin
      saturate = hi[fir_eq_pkg::SampleW-1:0];
    end else if (v < lo) begin
      saturate = lo[fir_eq_pkg::SampleW-1:0];
    end else begin
      saturate = v[fir_eq_pkg::SampleW-1:0];
    end
  endfunction

  always_comb begin
    logic signed [fir_eq_pkg::AccW-1:0] acc;
    logic signed [ProdW-1:0] prod;
    logic [4:0] sideShift;
    acc = '0;
    prod = '0;
    // Side taps carry LSB weight 2^(field-16): larger field, more range, less precision
    sideShift = 5'(fir_eq_pkg::ScwBase) - {2'h0, sideWeight};
    for (int k = 0; k < NumTaps; k++) begin
      prod = $signed(samples[k]) * $signed(coefs[k]);
      if (k == Center) begin
        acc = acc + fir_eq_pkg::AccW'(prod >>> fir_eq_pkg::CenterShift);
      end else begin
        acc = acc + fir_eq_pkg::AccW'(prod >>> sideShift);
      end
    end
    result = saturate(acc);
  end
endmodule // fir_tap_sum

// ---- hw/prog_fir_equalizer_config.sv ----
// Configuration, coefficient storage and sample path of the programmable equalizer filter.
// Assumes a classic Wishbone master on clk_sys and a same-clock sample source and sink.
// Function
// - A mode value of 0 disables the filter, 2 enables it, and 1 and 3 are reserved.
// - With the sharing bit or the merge bit set channel B uses the channel A coefficients, otherwise its own set.
// - With the merge bit set both channel filters act as one filter over a single sample stream.
// - The side weight field gives every non-center tap an LSB weight of two to the (field minus 16).
// - The first coefficient register holds a signed 12-bit first tap of channel A or the merged filter.
// - Further channel A coefficient registers follow at steps of two, each the next tap.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module prog_fir_equalizer_config #(
  parameter int NumTaps = 5
) (
  input wire logic clk_sys, // System clock, 25 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [15:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lane selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire fir_eq_pkg::sample_pair_s sampleIn, // Converter sample pair
  input wire logic sampleInValid, // Sample pair valid
  output logic sampleInReady, // Block takes a pair
  output fir_eq_pkg::sample_pair_s sampleOut, // Filtered pair toward the link
  output logic sampleOutValid, // Output pair valid
  input wire logic sampleOutReady // Link takes a pair
);
  localparam int SW = fir_eq_pkg::SampleW;

  if (NumTaps < 3 || (NumTaps % 2) == 0 || NumTaps > 16) begin : gCheck
    $error("prog_fir_equalizer_config: NumTaps must be odd and within 3..16");
  end

  typedef struct packed {
    logic [7:0] cfg;
    logic [NumTaps-1:0][fir_eq_pkg::RegW-1:0] coefA;
    logic [NumTaps-1:0][fir_eq_pkg::RegW-1:0] coefB;
    logic [NumTaps:0][SW-1:0] histA;
    logic [NumTaps-1:0][SW-1:0] histB;
    logic ack;
    logic [31:0] rdData;
    logic [15:0] pairCount;
  } cfg_state_s;

  cfg_state_s cur_ff;
  cfg_state_s nxt_cur;
  logic rstMeta_ff;
  logic rstSyncN;

  logic bufReady;
  logic [2*SW-1:0] bufOutData;
  logic bufOutValid;
  logic [SW-1:0] sumA;
  logic [SW-1:0] sumB;
  logic [NumTaps:0][SW-1:0] shiftA;
  logic [NumTaps-1:0][SW-1:0] shiftB;
  logic [NumTaps-1:0][SW-1:0] winA;
  logic [NumTaps-1:0][SW-1:0] winB;
  logic [NumTaps-1:0][fir_eq_pkg::CoefW-1:0] tapsA;
  logic [NumTaps-1:0][fir_eq_pkg::CoefW-1:0] tapsB;
  fir_eq_pkg::sample_pair_s pushData;

  // Returns the tap number addressed within a coefficient bank, or -1
  function automatic int tapOf(input logic [10:0] idx, input logic [10:0] base);
    logic [10:0] off;
    off = idx - base;
    if (idx >= base && !off[0] && off < 11'(2 * NumTaps)) begin
      tapOf = int'(off[10:1]);
    end else begin
      tapOf = -1;
    end
  endfunction

  // Applies the low two byte lanes of a write to a 16-bit register
  function automatic logic [15:0] laneWrite(input logic [15:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
    laneWrite = old;
    if (sel[0]) begin
      laneWrite[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      laneWrite[15:8] = dat[15:8];
    end
  endfunction

  // Reset release passes two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_ff <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSyncN <= rstMeta_ff;
    end
  end

  fir_tap_sum #(
    .NumTaps(NumTaps)
  ) uSumA (
    .samples(winA),
    .coefs(tapsA),
    .sideWeight(cur_ff.cfg[fir_eq_pkg::ScwLsb +: 3]),
    .result(sumA)
  );

  fir_tap_sum #(
    .NumTaps(NumTaps)
  ) uSumB (
    .samples(winB),
    .coefs(tapsB),
    .sideWeight(cur_ff.cfg[fir_eq_pkg::ScwLsb +: 3]),
    .result(sumB)
  );

  two_entry_buffer #(
    .Width(2 * SW),
    .Depth(2)
  ) uOutBuf (
    .clk_sys(clk_sys),
    .rstSyncN(rstSyncN),
    .inData(pushData),
    .inValid(sampleInValid),
    .inReady(bufReady),
    .outData(bufOutData),
    .outValid(bufOutValid),
    .outReady(sampleOutReady)
  );

  // Sample path: windows and coefficient choice for both channels
  always_comb begin
    logic merge;
    logic share;
    merge = cur_ff.cfg[fir_eq_pkg::MergeBit];
    share = cur_ff.cfg[fir_eq_pkg::ShareBit];
    // Merged: A then B are consecutive samples of one stream, B the newer
    if (merge) begin
      shiftA = {cur_ff.histA[NumTaps-2:0], sampleIn.chanA, sampleIn.chanB};
    end else begin
      shiftA = {cur_ff.histA[NumTaps-1:0], sampleIn.chanA};
    end
    shiftB = {cur_ff.histB[NumTaps-2:0], sampleIn.chanB};
    winA = merge ? shiftA[NumTaps:1] : shiftA[NumTaps-1:0];
    winB = merge ? shiftA[NumTaps-1:0] : shiftB;
    for (int k = 0; k < NumTaps; k++) begin
      tapsA[k] = cur_ff.coefA[k][fir_eq_pkg::CoefW-1:0];
      // The merged filter runs entirely on the channel A tap set
      tapsB[k] = (share || merge) ? cur_ff.coefA[k][fir_eq_pkg::CoefW-1:0]
                                  : cur_ff.coefB[k][fir_eq_pkg::CoefW-1:0];
    end
    // Reserved mode values leave the filter bypassed as well
    if (cur_ff.cfg[fir_eq_pkg::ModeLsb +: 2] == fir_eq_pkg::ModeEnable) begin
      pushData.chanA = sumA;
      pushData.chanB = sumB;
    end else begin
      pushData = sampleIn;
    end
  end

  // Register bus and history update
  always_comb begin
    logic req;
    logic [10:0] idx;
    logic mapped;
    int ta;
    int tb;
    req = wb_cyc_i && wb_stb_i;
    idx = wb_adr_i[12:2];
    mapped = (wb_adr_i[15:13] == 3'h0);
    ta = mapped ? tapOf(idx, fir_eq_pkg::CoefATap0Idx) : -1;
    tb = mapped ? tapOf(idx, fir_eq_pkg::CoefBTap0Idx) : -1;
    nxt_cur = cur_ff;

    // Ack one cycle after the request, dropped the cycle after
    nxt_cur.ack = req && !cur_ff.ack;
    if (req && !cur_ff.ack) begin
      nxt_cur.rdData = '0;
      if (mapped && idx == fir_eq_pkg::CfgIdx) begin
        nxt_cur.rdData[7:0] = cur_ff.cfg;
      end else if (mapped && idx == fir_eq_pkg::StatusIdx) begin
        nxt_cur.rdData[fir_eq_pkg::StActiveBit] =
          (cur_ff.cfg[fir_eq_pkg::ModeLsb +: 2] == fir_eq_pkg::ModeEnable);
        nxt_cur.rdData[fir_eq_pkg::StReservedModeBit] = cur_ff.cfg[fir_eq_pkg::ModeLsb];
        nxt_cur.rdData[fir_eq_pkg::StScwIllegalBit] =
          (cur_ff.cfg[fir_eq_pkg::ScwLsb +: 3] > fir_eq_pkg::ScwMax);
        nxt_cur.rdData[fir_eq_pkg::StOutValidBit] = bufOutValid;
        nxt_cur.rdData[fir_eq_pkg::StCountLsb +: 16] = cur_ff.pairCount;
      end else if (ta >= 0) begin
        nxt_cur.rdData[15:0] = cur_ff.coefA[ta];
      end else if (tb >= 0) begin
        nxt_cur.rdData[15:0] = cur_ff.coefB[tb];
      end
    end

    // Writes land on the edge where the master sees ack
    if (req && cur_ff.ack && wb_we_i) begin
      if (mapped && idx == fir_eq_pkg::CfgIdx && wb_sel_i[0]) begin
        nxt_cur.cfg = wb_dat_i[7:0];
      end else if (ta >= 0) begin
        nxt_cur.coefA[ta] = laneWrite(cur_ff.coefA[ta], wb_dat_i, wb_sel_i);
      end else if (tb >= 0) begin
        nxt_cur.coefB[tb] = laneWrite(cur_ff.coefB[tb], wb_dat_i, wb_sel_i);
      end
    end

    // Histories keep running while bypassed so enabling starts from real data
    if (sampleInValid && bufReady) begin
      nxt_cur.histA = shiftA;
      nxt_cur.histB = shiftB;
      nxt_cur.pairCount = cur_ff.pairCount + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign wb_ack_o = cur_ff.ack;
  assign wb_dat_o = cur_ff.rdData;
  assign sampleInReady = bufReady;
  assign sampleOut = fir_eq_pkg::sample_pair_s'(bufOutData);
  assign sampleOutValid = bufOutValid;
endmodule // prog_fir_equalizer_config

// ---- hw/two_entry_buffer.sv ----
// Small valid/ready FIFO on the sample output path.
// Assumes one clock; both sides handshake on valid and ready in the same cycle.
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int Width = 24,
  parameter int Depth = 2
) (
  input wire logic clk_sys, // System clock
  input wire logic rstSyncN, // Synchronised reset, active low
  input wire logic [Width-1:0] inData, // Word offered
  input wire logic inValid, // Word offered is valid
  output logic inReady, // Buffer can take a word
  output logic [Width-1:0] outData, // Head word
  output logic outValid, // Head word is valid
  input wire logic outReady // Consumer takes the head
);
  localparam int PtrW = (Depth > 1) ? $clog2(Depth) : 1;
  localparam int CntW = $clog2(Depth + 1);

  if (Depth < 2 || (Depth & (Depth - 1)) != 0) begin : gCheck
    $error("two_entry_buffer: Depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [Depth-1:0][Width-1:0] mem;
    logic [PtrW-1:0] wrPtr;
    logic [PtrW-1:0] rdPtr;
    logic [CntW-1:0] count;
    logic inReady;
    logic outValid;
    logic [Width-1:0] outData;
  } buf_state_s;

  buf_state_s cur_ff;
  buf_state_s nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    if (inValid && cur_ff.inReady) begin
      nxt_cur.mem[cur_ff.wrPtr] = inData;
      nxt_cur.wrPtr = cur_ff.wrPtr + PtrW'(1);
    end
    if (cur_ff.outValid && outReady) begin
      nxt_cur.rdPtr = cur_ff.rdPtr + PtrW'(1);
    end
    nxt_cur.count = cur_ff.count + CntW'(inValid && cur_ff.inReady) - CntW'(cur_ff.outValid && outReady);
    // A stalled consumer lets the count reach Depth, which drops inReady
    nxt_cur.inReady = (nxt_cur.count != CntW'(Depth));
    nxt_cur.outValid = (nxt_cur.count != '0);
    nxt_cur.outData = nxt_cur.mem[nxt_cur.rdPtr];
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign inReady = cur_ff.inReady;
  assign outValid = cur_ff.outValid;
  assign outData = cur_ff.outData;
endmodule // two_entry_buffer

// ---- testbench/fir_eq_checker_asserts.sv ----
// Port checker for the equalizer filter block.
// Assumes it is bound into prog_fir_equalizer_config and sees only its ports.
`timescale 1ns/1ps
module fir_eq_checker #(
  parameter int NumTaps = 5
) (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [15:0] wb_adr_i, // Address
  input wire logic [3:0] wb_sel_i, // Lanes
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire fir_eq_pkg::sample_pair_s sampleIn, // Pair in
  input wire logic sampleInValid, // In valid
  input wire logic sampleInReady, // In ready
  input wire fir_eq_pkg::sample_pair_s sampleOut, // Pair out
  input wire logic sampleOutValid, // Out valid
  input wire logic sampleOutReady // Out ready
);
  logic [7:0] cfg_ff;
  logic [15:0] tap0_ff;
  logic wrAck;
  assign wrAck = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
  // Shadows follow the bus so reads can be judged without seeing inside
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= 8'h00;
      tap0_ff <= 16'h0000;
    end else if (wrAck) begin
      if (wb_adr_i == 16'h1000 && wb_sel_i[0]) cfg_ff <= wb_dat_i[7:0];
      if (wb_adr_i == 16'h1060 && wb_sel_i[0]) tap0_ff[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i == 16'h1060 && wb_sel_i[1]) tap0_ff[15:8] <= wb_dat_i[15:8];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_CFG_READ: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 16'h1000 |-> wb_dat_o == {24'h0, cfg_ff})
    else $error("config read differs from last write");
  AST_TAP0_READ: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 16'h1060 |-> wb_dat_o == {16'h0, tap0_ff})
    else $error("first tap read differs from last write");
  AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i[15:12] != 4'h1 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_BYPASS: assert property ($past(sampleInValid && sampleInReady) && $rose(sampleOutValid)
    && cfg_ff[1:0] != 2'h2 |-> sampleOut == $past(sampleIn))
    else $error("disabled filter altered a pair");
  AST_OUT_HOLD: assert property (sampleOutValid && !sampleOutReady |=> sampleOutValid && $stable(sampleOut))
    else $error("stalled output pair changed");
  AST_OUT_LATENCY: assert property (sampleInValid && sampleInReady && !sampleOutValid |=> sampleOutValid)
    else $error("output pair late");
endmodule // fir_eq_checker

bind prog_fir_equalizer_config fir_eq_checker #(.NumTaps(NumTaps)) chk_u (
  .clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .sampleIn, .sampleInValid, .sampleInReady,
  .sampleOut, .sampleOutValid, .sampleOutReady
);

// ---- testbench/testbench.sv ----
// Self-checking bench for the equalizer filter block.
// Assumes the port checker is bound in and one clock drives bus and stream.
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbWe = 1'b0;
  logic [15:0] wbAdr = 16'h0000;
  logic [31:0] wbDatW = 32'h0;
  logic [31:0] wbDatR;
  logic wbAck;
  fir_eq_pkg::sample_pair_s inPair = '0;
  logic inValid = 1'b0;
  logic inReady;
  fir_eq_pkg::sample_pair_s outPair;
  logic outValid;
  logic outReady = 1'b1;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;

  always #20 clk_sys = ~clk_sys;

  prog_fir_equalizer_config #(.NumTaps(5)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbCyc), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'h3), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .sampleIn(inPair), .sampleInValid(inValid), .sampleInReady(inReady), .sampleOut(outPair),
    .sampleOutValid(outValid), .sampleOutReady(outReady)
  );

  task automatic tally_and_finish();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Request held until the edge that samples ack; data taken and request dropped at that edge
  // Registers are only touched between pairs, as software does with the link disabled
  task automatic wb(input logic we, input logic [15:0] adr, input logic [31:0] dat);
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= dat;
    do @(posedge clk_sys); while (wbAck !== 1'b1);
    rd = wbDatR;
    wbCyc <= 1'b0;
  endtask

  task automatic chk(input string name, input logic [15:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    cmp(name, exp, rd);
  endtask

  task automatic put(input logic [23:0] p);
    @(posedge clk_sys);
    inPair <= p;
    inValid <= 1'b1;
    do @(posedge clk_sys); while (inReady !== 1'b1);
    inValid <= 1'b0;
  endtask

  task automatic get(input string name, input logic [23:0] p);
    do @(negedge clk_sys); while (outValid !== 1'b1);
    cmp(name, {8'h0, p}, {8'h0, outPair});
    @(posedge clk_sys);
  endtask

  task automatic test_regs();
    chk("cfg reset", 16'h1000, 32'h0);
    chk("tap0 reset", 16'h1060, 32'h0);
    wb(1'b1, 16'h1070, 32'hfabc);
    chk("tap2", 16'h1070, 32'hfabc);
    wb(1'b1, 16'h1000, 32'hfe);
    chk("cfg", 16'h1000, 32'hfe);
    // Mode 2 shows active, weight 7 is flagged, no pair taken yet
    chk("status", 16'h1004, 32'h5);
    wb(1'b1, 16'h2000, 32'h55);
    chk("unmapped", 16'h2000, 32'h0);
    wb(1'b1, 16'h1070, 32'h0);
  endtask

  // Only the first tap is set, so each output depends on its own pair alone
  task automatic test_weight();
    wb(1'b1, 16'h1060, 32'h400);
    wb(1'b1, 16'h1000, 32'h1a);
    put(24'h000100);
    get("weight 6", 24'h000100);
    wb(1'b1, 16'h1000, 32'h02);
    put(24'h000100);
    get("weight 0", 24'h000004);
  endtask

  task automatic test_modes();
    wb(1'b1, 16'h1060, 32'hc00);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, 16'h1000, 32'h18 + 32'(m));
      put(24'h050100);
      get("mode", (m == 2) ? 24'h000f00 : 24'h050100);
    end
  endtask

  task automatic test_share();
    wb(1'b1, 16'h1000, 32'h5a);
    put(24'h050100);
    get("share", 24'hfb0f00);
  endtask

  // Second tap picks the previous sample of the merged stream; before merging
  // the history holds channel A samples only, so the first A result is the last A input
  task automatic test_merge();
    wb(1'b1, 16'h1060, 32'h0);
    wb(1'b1, 16'h1068, 32'h400);
    wb(1'b1, 16'h1000, 32'h3a);
    put(24'h002001);
    get("merge 1", 24'h001100);
    put(24'h007005);
    get("merge 2", 24'h005002);
  endtask

  task automatic test_stall();
    int n;
    n = 0;
    wb(1'b1, 16'h1000, 32'h0);
    @(posedge clk_sys);
    outReady <= 1'b0;
    inValid <= 1'b1;
    inPair <= 24'h000001;
    repeat (8) begin
      @(posedge clk_sys);
      if (inReady) begin
        n++;
        inPair <= 24'(n + 1);
      end
    end
    inValid <= 1'b0;
    outReady <= 1'b1;
    cmp("accepted", 32'd2, 32'(n));
    get("drain 1", 24'h000001);
    get("drain 2", 24'h000002);
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    test_regs();
    test_weight();
    test_modes();
    test_share();
    test_merge();
    test_stall();
    tally_and_finish();
  end
endmodule // testbench
